// [scl_params.svh]
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// Control register layout: frequency controls in the upper byte
`define SCL_CTRL_BYTE_LSB   8
`define SCL_CTRL_W_BIT      15
`define SCL_CTRL_X_BIT      14
`define SCL_CTRL_Y_MSB      13
`define SCL_CTRL_Y_LSB      8
`define SCL_CTRL_LOCK_BIT   3
`define SCL_CTRL_RST        8'h3F
`define SCL_LOCK_MASK       16'h0008

// Reference prescale for the high range: divide by 128
`define SCL_HI_DIV_LAST     7'h7F

// Lock detector: tolerance in MCLK cycles and matching periods needed
`define SCL_LOCK_TOL        16'h0002
`define SCL_LOCK_HITS       3'h4
`define SCL_PER_MAX         16'hFFFF

// Multiplier used when the synthesizer is bypassed
`define SCL_MULT_BYPASS     12'h001
`define SCL_MULT_RST        12'h100

`endif

// [scl_pkg.sv]
package scl_pkg;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b10
  } scl_state_t;

  typedef logic [11:0] scl_mult_t;

endpackage : scl_pkg

// [scl_lock_det.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scl_params.svh"

module scl_lock_det (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Comparator inputs
  input  wire logic restart,
  input  wire logic ref_tick,
  input  wire logic fb_tick,
  // Status
  output var  logic locked
);

  logic [15:0] ref_cnt_q;
  logic [15:0] fb_cnt_q;
  logic [15:0] fb_per_q;
  logic [2:0]  hits_q;
  logic [15:0] diff;
  logic        match;

  // Periods measured in MCLK cycles; counters saturate when a source stalls
  assign diff  = (ref_cnt_q > fb_per_q) ? (ref_cnt_q - fb_per_q) : (fb_per_q - ref_cnt_q);
  assign match = (fb_per_q != 16'h0000) && (ref_cnt_q != 16'h0000) && (diff <= `SCL_LOCK_TOL);

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      ref_cnt_q <= 16'h0000;
      fb_cnt_q  <= 16'h0000;
      fb_per_q  <= 16'h0000;
      hits_q    <= 3'h0;
      locked    <= 1'b0;
    end else begin
      ref_cnt_q <= ref_tick ? 16'h0000 : ((ref_cnt_q == `SCL_PER_MAX) ? ref_cnt_q : ref_cnt_q + 16'h0001);
      fb_cnt_q  <= fb_tick ? 16'h0000 : ((fb_cnt_q == `SCL_PER_MAX) ? fb_cnt_q : fb_cnt_q + 16'h0001);
      if (fb_tick) begin
        fb_per_q <= fb_cnt_q;
      end
      if (ref_tick) begin
        if (!match) begin
          hits_q <= 3'h0;
        end else if (hits_q != `SCL_LOCK_HITS) begin
          hits_q <= hits_q + 3'h1;
        end
      end
      locked <= (hits_q == `SCL_LOCK_HITS);
    end
  end

  lock_needs_hits_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(locked) |-> $past(hits_q) == `SCL_LOCK_HITS)
    else $error("Lock rose without enough matching periods");

  restart_unlock_a: assert property (
    @(posedge clk) disable iff (rst)
    restart |=> !locked [*2])
    else $error("Lock held across a comparator input change");

endmodule : scl_lock_det
`default_nettype wire

// [scl_clock_ctrl.sv]
// Function
// - With the source-select pin high during reset, the system clock comes from the synthesizer fed by the reference input.
// - With the pin low during reset, the synthesizer is bypassed and the frequency controls have no effect.
// - The pin must be held at the mode level through reset and serves as port F bit zero only afterwards.
// - In the high reference range the reference is divided by 128 before reaching the loop.
// - Lock is declared once the divided feedback matches the (possibly divided) reference.
// - The lock condition is readable as a flag in the control register.
// - Any change of a comparator input drops the lock flag until relock.
// - In synthesizer mode the chip is kept in reset until the synthesizer reports lock; in bypass it is released without waiting.
// - Register contents are kept unchanged when the clock rate changes.
// - The upper byte holds the controls; the multiplier is 4 times (modulus plus one) times 2 to the (2W+X).
// - The divide-select bit changes the rate without relock; prescale tap or modulus changes force relock.
// - After reset the controls give modulus 63 with W and X cleared, a multiplier of 256.
`timescale 1ns/1ps
`default_nettype none
`include "scl_params.svh"

module scl_clock_ctrl (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // Pins
  input  wire logic        CLK_SRC_SEL_PIN,
  input  wire logic        REF_CLK_IN,
  input  wire logic        VCO_FB_IN,
  // Configuration
  input  wire logic        HIGH_RANGE_SEL,
  // Control register write
  input  wire logic        CTRL_WR,
  input  wire logic [15:0] CTRL_WDATA,
  // Status and clock controls
  output var  logic [15:0] CTRL_RDATA,
  output var  logic        SYNTH_LOCK_FLAG,
  output var  logic        SYNTH_MODE,
  output var  logic [11:0] SYS_CLK_MULT,
  output var  logic [10:0] VCO_FB_DIV,
  output var  logic        CHIP_RST_HOLD,
  output var  logic        PORT_F_BIT_ZERO
);

  // Multiplier 4*(Y+1)*2^(2W+X); feedback divisor is the same with X forced low
  function automatic scl_pkg::scl_mult_t mult_f(input logic w, input logic x, input logic [5:0] y);
    scl_pkg::scl_mult_t b;
    b = {6'h00, y} + 12'h001;
    b = b << 2;
    if (w) begin
      b = b << 2;
    end
    if (x) begin
      b = b << 1;
    end
    mult_f = b;
  endfunction : mult_f

  logic              src_s1_q;
  logic              src_s2_q;
  logic              ref_s1_q;
  logic              ref_s2_q;
  logic              ref_s3_q;
  logic              fb_s1_q;
  logic              fb_s2_q;
  logic              fb_s3_q;
  logic              mode_q;
  logic [7:0]        ctrl_q;
  logic [6:0]        hdiv_q;
  logic [10:0]       fbcnt_q;
  logic              hr_q;
  logic              relock_q;
  scl_pkg::scl_state_t state_q;
  scl_pkg::scl_state_t state_d;

  wire logic         ref_rise;
  wire logic         fb_rise;
  wire logic         eff_ref_tick;
  wire logic         fb_tick;
  wire logic         fb_change;
  wire logic         relock_d;
  wire logic         det_restart;
  wire logic         det_locked;
  wire logic         lock_now;
  wire logic         ctl_w;
  wire logic         ctl_x;
  wire logic [5:0]   ctl_y;
  wire logic [10:0]  fb_div;
  wire scl_pkg::scl_mult_t mult_now;

  assign ctl_w    = ctrl_q[`SCL_CTRL_W_BIT - `SCL_CTRL_BYTE_LSB];
  assign ctl_x    = ctrl_q[`SCL_CTRL_X_BIT - `SCL_CTRL_BYTE_LSB];
  assign ctl_y    = ctrl_q[`SCL_CTRL_Y_MSB - `SCL_CTRL_BYTE_LSB:`SCL_CTRL_Y_LSB - `SCL_CTRL_BYTE_LSB];
  assign mult_now = mult_f(ctl_w, ctl_x, ctl_y);
  assign fb_div   = 11'(mult_f(ctl_w, 1'b0, ctl_y));

  // Edge detectors read only the second and third stages
  assign ref_rise     = ref_s2_q & ~ref_s3_q;
  assign fb_rise      = fb_s2_q & ~fb_s3_q;
  assign eff_ref_tick = HIGH_RANGE_SEL ? (ref_rise && (hdiv_q == `SCL_HI_DIV_LAST)) : ref_rise;
  assign fb_tick      = fb_rise && (fbcnt_q == fb_div - 11'h001);

  // X sits outside the feedback loop, so only W and Y count as a change
  assign fb_change   = CTRL_WR && ((CTRL_WDATA[`SCL_CTRL_W_BIT] != ctl_w) ||
                       (CTRL_WDATA[`SCL_CTRL_Y_MSB:`SCL_CTRL_Y_LSB] != ctl_y));
  assign relock_d    = fb_change || (HIGH_RANGE_SEL != hr_q);
  assign det_restart = relock_q || !mode_q;
  assign lock_now    = mode_q && det_locked && !relock_q;

  // Input synchronisers
  always_ff @(posedge MCLK) begin
    src_s1_q <= CLK_SRC_SEL_PIN;
    src_s2_q <= src_s1_q;
    ref_s1_q <= REF_CLK_IN;
    ref_s2_q <= ref_s1_q;
    ref_s3_q <= ref_s2_q;
    fb_s1_q  <= VCO_FB_IN;
    fb_s2_q  <= fb_s1_q;
    fb_s3_q  <= fb_s2_q;
  end

  // Mode strap follows the pin only while reset is held
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mode_q <= src_s2_q;
    end
  end

  // Only reset or a write touches the controls; a rate change alone leaves them alone
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_q <= `SCL_CTRL_RST;
    end else if (CTRL_WR) begin
      ctrl_q <= CTRL_WDATA[`SCL_CTRL_W_BIT:`SCL_CTRL_BYTE_LSB];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hdiv_q   <= 7'h00;
      fbcnt_q  <= 11'h000;
      hr_q     <= HIGH_RANGE_SEL;
      relock_q <= 1'b0;
    end else begin
      hdiv_q   <= ref_rise ? hdiv_q + 7'h01 : hdiv_q;
      fbcnt_q  <= (relock_q || fb_tick) ? 11'h000 : (fb_rise ? fbcnt_q + 11'h001 : fbcnt_q);
      hr_q     <= HIGH_RANGE_SEL;
      relock_q <= relock_d;
    end
  end

  scl_lock_det u_lock_det (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .restart  (det_restart),
    .ref_tick (eff_ref_tick),
    .fb_tick  (fb_tick),
    .locked   (det_locked)
  );

  // Reset release waits for lock in synthesizer mode only; a later relock does not reassert it
  always_comb begin
    state_d = state_q;
    case (state_q)
      scl_pkg::ST_RESET: begin
        state_d = scl_pkg::ST_WAIT;
      end
      scl_pkg::ST_WAIT: begin
        if (!mode_q || det_locked) begin
          state_d = scl_pkg::ST_RUN;
        end
      end
      scl_pkg::ST_RUN: begin
        state_d = scl_pkg::ST_RUN;
      end
      default: begin
        state_d = scl_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_q         <= scl_pkg::ST_RESET;
      CHIP_RST_HOLD   <= 1'b1;
      SYNTH_LOCK_FLAG <= 1'b0;
      SYNTH_MODE      <= 1'b0;
      SYS_CLK_MULT    <= `SCL_MULT_BYPASS;
      VCO_FB_DIV      <= 11'h000;
      CTRL_RDATA      <= 16'h0000;
      PORT_F_BIT_ZERO <= 1'b0;
    end else begin
      state_q         <= state_d;
      CHIP_RST_HOLD   <= (state_d != scl_pkg::ST_RUN);
      SYNTH_LOCK_FLAG <= lock_now;
      SYNTH_MODE      <= mode_q;
      SYS_CLK_MULT    <= mode_q ? mult_now : `SCL_MULT_BYPASS;
      VCO_FB_DIV      <= mode_q ? fb_div : 11'h000;
      CTRL_RDATA      <= {ctrl_q, 4'h0, lock_now, 3'h0};
      PORT_F_BIT_ZERO <= src_s2_q;
    end
  end

  synth_select_a: assert property (
    @(posedge MCLK) SYS_RST && src_s2_q ##1 !SYS_RST |-> mode_q ##1 SYNTH_MODE)
    else $error("High strap did not select the synthesizer");

  bypass_mult_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !mode_q |=> SYS_CLK_MULT == `SCL_MULT_BYPASS)
    else $error("Frequency controls acted in bypass mode");

  port_after_rst_a: assert property (
    @(posedge MCLK) SYS_RST |=> !PORT_F_BIT_ZERO)
    else $error("Port bit driven during reset");

  hi_range_div_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    HIGH_RANGE_SEL && eff_ref_tick |-> ref_rise && hdiv_q == `SCL_HI_DIV_LAST)
    else $error("High range reference not divided by 128");

  // Prescaler must step once per reference edge and wrap after 128
  hdiv_step_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    ref_rise |=> hdiv_q == $past(hdiv_q) + 7'h01)
    else $error("Reference prescaler skipped a count");

  lock_flag_read_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    CTRL_RDATA[`SCL_CTRL_LOCK_BIT] == SYNTH_LOCK_FLAG)
    else $error("Lock flag and register bit disagree");

  relock_drop_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    relock_q |=> !SYNTH_LOCK_FLAG ##1 !SYNTH_LOCK_FLAG)
    else $error("Lock flag stayed up after a feedback change");

  rst_until_lock_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    $fell(CHIP_RST_HOLD) |-> !SYNTH_MODE || $past(det_locked, 1))
    else $error("Reset released before lock");

  ctrl_kept_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !CTRL_WR |=> $stable(ctrl_q))
    else $error("Control register changed without a write");

  x_no_relock_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    CTRL_WR && !fb_change && HIGH_RANGE_SEL == hr_q |=> !relock_q)
    else $error("Divide select forced a relock");

  reset_mult_a: assert property (
    @(posedge MCLK) SYS_RST ##1 !SYS_RST && !CTRL_WR && mode_q |=> SYS_CLK_MULT == `SCL_MULT_RST)
    else $error("Reset multiplier is not 256");

  lock_read_only_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    CTRL_WR && CTRL_WDATA[`SCL_CTRL_LOCK_BIT] && !det_locked ##1 !det_locked
    |=> !SYNTH_LOCK_FLAG && !CTRL_RDATA[`SCL_CTRL_LOCK_BIT])
    else $error("Write set the lock flag");

endmodule : scl_clock_ctrl
`default_nettype wire

// [scl_ref_osc.sv]
`timescale 1ns/1ps
`default_nettype none

module scl_ref_osc #(
  parameter int HALF_NS = 12800
) (
  // Loop setting and fault control
  input  wire logic [10:0] fb_div,
  input  wire logic        detune,
  // Pins
  output var  logic        ref_clk,
  output var  logic        vco_fb
);
  initial ref_clk = 1'b0;
  initial vco_fb = 1'b0;
  // Slow steady reference, far below the system clock limit
  always #(HALF_NS) ref_clk = ~ref_clk;
  // VCO stands still in bypass or before the divisor is driven; detune halves its rate
  always begin
    if ($isunknown(fb_div) || fb_div == 11'h000)
      #(100) vco_fb = 1'b0;
    else
      #((HALF_NS / fb_div) * (detune ? 2 : 1)) vco_fb = ~vco_fb;
  end
endmodule : scl_ref_osc

`default_nettype wire

// [scl_testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        mclk;
  logic        sys_rst;
  logic        src_pin;
  logic        hi_range;
  logic        ctrl_wr;
  logic [15:0] ctrl_wdata;
  logic        detune;
  logic        ref_clk;
  logic        vco_fb;
  logic [15:0] rdata;
  logic        lock;
  logic        mode;
  logic [11:0] mult;
  logic [10:0] fb_div;
  logic        hold;
  logic        port_f;
  int          miscompares = 0;
  int          checks_done = 0;

  scl_clock_ctrl dut (
    .MCLK(mclk), .SYS_RST(sys_rst), .CLK_SRC_SEL_PIN(src_pin), .REF_CLK_IN(ref_clk),
    .VCO_FB_IN(vco_fb), .HIGH_RANGE_SEL(hi_range), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata),
    .CTRL_RDATA(rdata), .SYNTH_LOCK_FLAG(lock), .SYNTH_MODE(mode), .SYS_CLK_MULT(mult),
    .VCO_FB_DIV(fb_div), .CHIP_RST_HOLD(hold), .PORT_F_BIT_ZERO(port_f)
  );

  scl_ref_osc osc (.fb_div(fb_div), .detune(detune), .ref_clk(ref_clk), .vco_fb(vco_fb));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Outputs settle one edge after the write edge
  task automatic wr(input logic [15:0] d);
    @(negedge mclk);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(negedge mclk);
    ctrl_wr = 1'b0;
    cyc(2);
  endtask : wr

  // Bound covers about twelve reference periods
  task automatic wait_lock(input logic exp);
    for (int i = 0; i < 12000 && lock !== exp; i++)
      @(negedge mclk);
  endtask : wait_lock

  // Strap needs more than two edges to pass the synchroniser
  task automatic do_reset(input logic pin);
    @(negedge mclk);
    sys_rst = 1'b1;
    src_pin = pin;
    cyc(4);
    chk(hold, 1'b1);
    chk({lock, port_f}, 2'b00);
    chk(rdata, 16'h0000);
    sys_rst = 1'b0;
    cyc(1);
    chk(mode, pin);
    chk(rdata, 16'h3F00);
    chk(mult, pin ? 12'h100 : 12'h001);
  endtask : do_reset

  task automatic t_synth_lock;
    do_reset(1'b1);
    chk(fb_div, 11'h100);
    chk(hold, 1'b1);
    wait_lock(1'b1);
    chk(lock, 1'b1);
    chk(hold, 1'b0);
    chk(rdata, 16'h3F08);
  endtask : t_synth_lock

  task automatic t_no_relock(input logic [15:0] d, input logic [15:0] rd, input logic [11:0] m);
    wr(d);
    chk(mult, m);
    chk(rdata, rd);
    cyc(20);
    chk(lock, 1'b1);
  endtask : t_no_relock

  task automatic t_relock(input logic [15:0] d, input logic [11:0] m, input logic [10:0] dv);
    wr(d);
    chk(lock, 1'b0);
    chk(mult, m);
    chk(fb_div, dv);
    chk(hold, 1'b0);
    wait_lock(1'b1);
    chk(rdata, {d[15:8], 8'h08});
  endtask : t_relock

  task automatic t_detune_range;
    detune = 1'b1;
    wait_lock(1'b0);
    chk(lock, 1'b0);
    detune = 1'b0;
    wait_lock(1'b1);
    chk(lock, 1'b1);
    hi_range = 1'b1;
    cyc(3);
    chk(lock, 1'b0);
    hi_range = 1'b0;
    wait_lock(1'b1);
    chk(lock, 1'b1);
  endtask : t_detune_range

  task automatic t_bypass;
    do_reset(1'b0);
    chk(fb_div, 11'h000);
    cyc(2);
    chk(hold, 1'b0);
    wr(16'h1F0F);
    chk(mult, 12'h001);
    chk(rdata, 16'h1F00);
    chk(lock, 1'b0);
    src_pin = 1'b1;
    cyc(4);
    chk(port_f, 1'b1);
    chk(mode, 1'b0);
  endtask : t_bypass

  initial begin
    sys_rst = 1'b1;
    src_pin = 1'b1;
    hi_range = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_wdata = 16'h0000;
    detune = 1'b0;
    cyc(2);
    t_synth_lock();
    t_no_relock(16'h7FF7, 16'h7F08, 12'h200);
    t_relock(16'h1F00, 12'h080, 11'h080);
    t_relock(16'h8F00, 12'h100, 11'h100);
    t_no_relock(16'hCF00, 16'hCF08, 12'h200);
    t_detune_range();
    t_bypass();
    final_report();
  end

  // Roughly three times the expected run length
  initial begin
    #(2_400_000);
    miscompares++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
